// ==== dbvc_pkg.sv ====
// dbvc_pkg: constants for the dual buck voltage control slave.
// assumes a 10 MHz core clock and a bus clock well below it.
package dbvc_pkg;
  // ---------------------------------------------
  // bus and register map
  // ---------------------------------------------
  localparam logic [6:0] DBVC_DEV_ADDR    = 7'h36;
  localparam logic [7:0] DBVC_IDX_CTRL    = 8'h00;
  localparam logic [7:0] DBVC_IDX_CH1     = 8'h01;
  localparam logic [7:0] DBVC_IDX_CH2     = 8'h02;
  localparam logic [3:0] DBVC_BITS_BYTE   = 4'h8;
  // ---------------------------------------------
  // fields
  // ---------------------------------------------
  localparam int         DBVC_CTRL_USTEP  = 0;
  localparam int         DBVC_CTRL_SS_EN  = 1;
  localparam int         DBVC_CTRL_FMOD   = 2;
  localparam int         DBVC_CH_PWM      = 5;
  localparam int         DBVC_CH2_GOOD_DIS = 6;
  localparam logic [7:0] DBVC_CTRL_RST    = 8'h04;
  localparam logic [7:0] DBVC_CH1_MASK    = 8'h3f;
  localparam logic [7:0] DBVC_CH2_MASK    = 8'h7f;
  // ---------------------------------------------
  // timing
  // ---------------------------------------------
  localparam int         DBVC_CLK_NS      = 100;
  localparam int         DBVC_STEP_US     = 32;
  localparam int         DBVC_STEP_CYC    = (DBVC_STEP_US * 1000) / DBVC_CLK_NS;
  localparam int         DBVC_TMR_W       = 9;
  // ---------------------------------------------
  // protocol states
  // ---------------------------------------------
  typedef enum logic [2:0] {
    DBVC_IDLE,
    DBVC_RX,
    DBVC_ACK,
    DBVC_TX,
    DBVC_MACK
  } dbvc_st_t;
endpackage

// ==== dbvc_top.sv ====
// dbvc_top: two-wire slave, three control registers, voltage code stepping.
// assumes scl and sda arrive asynchronously, open drain, with pull-ups outside.
//
// Contract
// - start is sda falling with scl high; stop is sda rising with scl high.
// - bus counts busy from start until stop, idle after stop.
// - a repeated start restarts address reception like a first start.
// - bytes are eight bits, most significant bit first.
// - a transfer may carry any number of bytes.
// - transmitter releases sda in acknowledge slot; receiver pulls low on ninth.
// - once addressed, every received byte is acknowledged.
// - first byte is seven address bits then direction, zero write one read.
// - the slave answers chip address 36h.
// - in a write, byte two is register index, byte three the value.
// - three read/write registers: control 00, channel 1 01, channel 2 02.
// - channel 2 register holds code, mode and indicator disable.
// - channel 1 takes 5-bit codes 00101 to 11001, 50 mV apart.
// - channel 2 takes 5-bit codes 00001 to 10000 in 100 mV steps.
// - without programming each channel uses its preset default code.
// - with micro-stepping enabled, codes move one step at a time.
// - channel 1 steps 50 mV every 32 us until target.
// - channel 2 steps 100 mV every 32 us until target.
// - sda changes only while scl is low, except start and stop.
// - a register bit forces a channel into fixed-frequency pwm.
// - spread spectrum rate bit: set is 1 kHz and default, clear 2 kHz.
`timescale 1ns/100ps
`default_nettype none
module dbvc_top
  import dbvc_pkg::*;
#(
  parameter logic [4:0] CH1_DEFAULT_CODE = 5'h09,
  parameter logic [4:0] CH2_DEFAULT_CODE = 5'h10
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       ce_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  output logic [4:0]      ch1_code_out,
  output logic [4:0]      ch2_code_out,
  output logic            ch1_force_pwm_out,
  output logic            ch2_force_pwm_out,
  output logic            ss_enable_out,
  output logic            ss_fmod_1k_out,
  output logic            output_good_indicator_dis_out,
  output logic            bus_busy_out,
  output logic            stepping_out
);

  // ---------------------------------------------
  // elaboration checks
  // ---------------------------------------------
  if (DBVC_STEP_CYC < 1 || DBVC_STEP_CYC >= (1 << DBVC_TMR_W)) begin : g_chk_tmr
    $error("step timer too narrow");
  end
  if (CH1_DEFAULT_CODE < 5'h05 || CH1_DEFAULT_CODE > 5'h19) begin : g_chk_c1
    $error("channel 1 default code out of range");
  end
  if (CH2_DEFAULT_CODE < 5'h01 || CH2_DEFAULT_CODE > 5'h10) begin : g_chk_c2
    $error("channel 2 default code out of range");
  end

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  typedef struct packed {
    logic                  scl_m;
    logic                  scl_s;
    logic                  scl_p;
    logic                  sda_m;
    logic                  sda_s;
    logic                  sda_p;
    dbvc_st_t              st;
    logic [3:0]            cnt;
    logic [1:0]            phase;
    logic                  rw;
    logic                  mack;
    logic                  busy;
    logic [7:0]            idx;
    logic [7:0]            sh;
    logic                  oe;
    logic [7:0]            ctrl;
    logic [7:0]            ch1;
    logic [7:0]            ch2;
    logic [4:0]            act1;
    logic [4:0]            act2;
    logic [DBVC_TMR_W-1:0] tmr;
    logic                  stp;
  } dbvc_state_t;

  dbvc_state_t s_r;
  dbvc_state_t s_nxt;

  localparam logic [DBVC_TMR_W-1:0] STEP_LAST = DBVC_TMR_W'(DBVC_STEP_CYC - 1);

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic [4:0] dbvc_step(input logic [4:0] cur, input logic [4:0] tgt);
    if (cur < tgt) begin
      dbvc_step = cur + 5'h01;
    end else if (cur > tgt) begin
      dbvc_step = cur - 5'h01;
    end else begin
      dbvc_step = cur;
    end
  endfunction

  function automatic logic [7:0] dbvc_rd(input dbvc_state_t s);
    case (s.idx)
      DBVC_IDX_CTRL: dbvc_rd = s.ctrl;
      DBVC_IDX_CH1:  dbvc_rd = s.ch1;
      DBVC_IDX_CH2:  dbvc_rd = s.ch2;
      default:       dbvc_rd = 8'h00;
    endcase
  endfunction

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic [7:0] byte_in;
  logic [4:0] tgt1;
  logic [4:0] tgt2;
  logic       ramp;
  logic [7:0] rd_byte;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.scl_m = scl_in;
    s_nxt.scl_s = s_r.scl_m;
    s_nxt.scl_p = s_r.scl_s;
    s_nxt.sda_m = sda_in;
    s_nxt.sda_s = s_r.sda_m;
    s_nxt.sda_p = s_r.sda_s;
    scl_rise = s_r.scl_s && !s_r.scl_p;
    scl_fall = !s_r.scl_s && s_r.scl_p;
    start_c  = s_r.scl_s && s_r.scl_p && s_r.sda_p && !s_r.sda_s;
    stop_c   = s_r.scl_s && s_r.scl_p && !s_r.sda_p && s_r.sda_s;
    byte_in  = s_r.sh;
    tgt1     = s_r.ch1[4:0];
    tgt2     = s_r.ch2[4:0];
    ramp     = (s_r.act1 != tgt1) || (s_r.act2 != tgt2);
    rd_byte  = dbvc_rd(s_r);

    if (start_c) begin
      // first and repeated start alike
      s_nxt.st    = DBVC_RX;
      s_nxt.cnt   = 4'h0;
      s_nxt.phase = 2'h0;
      s_nxt.oe    = 1'b0;
      s_nxt.busy  = 1'b1;
    end else if (stop_c) begin
      s_nxt.st   = DBVC_IDLE;
      s_nxt.oe   = 1'b0;
      s_nxt.busy = 1'b0;
    end else begin
      case (s_r.st)
        DBVC_IDLE: begin
          s_nxt.oe = 1'b0;
        end
        DBVC_RX: begin
          if (scl_rise) begin
            // msb first shift
            s_nxt.sh  = {s_r.sh[6:0], s_r.sda_s};
            s_nxt.cnt = s_r.cnt + 4'h1;
          end else if (scl_fall && s_r.cnt == DBVC_BITS_BYTE) begin
            // drive only after scl falls
            s_nxt.st  = DBVC_ACK;
            s_nxt.oe  = 1'b1;
            s_nxt.cnt = 4'h0;
            case (s_r.phase)
              2'h0: begin
                if (byte_in[7:1] == DBVC_DEV_ADDR) begin
                  s_nxt.rw    = byte_in[0];
                  s_nxt.phase = 2'h1;
                end else begin
                  s_nxt.st = DBVC_IDLE;
                  s_nxt.oe = 1'b0;
                end
              end
              2'h1: begin
                s_nxt.idx   = byte_in;
                s_nxt.phase = 2'h2;
              end
              default: begin
                // any number of data bytes, all acked
                case (s_r.idx)
                  DBVC_IDX_CTRL: s_nxt.ctrl = byte_in;
                  DBVC_IDX_CH1:  s_nxt.ch1  = byte_in & DBVC_CH1_MASK;
                  DBVC_IDX_CH2:  s_nxt.ch2  = byte_in & DBVC_CH2_MASK;
                  default:       s_nxt.ctrl = s_r.ctrl;
                endcase
              end
            endcase
          end
        end
        DBVC_ACK: begin
          // master clocks the slot; on its falling edge release, or in a read drive the first data bit
          if (scl_fall) begin
            s_nxt.cnt = 4'h0;
            if (s_r.rw) begin
              s_nxt.st = DBVC_TX;
              s_nxt.sh = rd_byte;
              s_nxt.oe = !rd_byte[7];
            end else begin
              s_nxt.st = DBVC_RX;
              s_nxt.oe = 1'b0;
            end
          end
        end
        DBVC_TX: begin
          if (scl_rise) begin
            s_nxt.cnt = s_r.cnt + 4'h1;
          end else if (scl_fall) begin
            if (s_r.cnt == DBVC_BITS_BYTE) begin
              s_nxt.st = DBVC_MACK;
              s_nxt.oe = 1'b0;
            end else begin
              s_nxt.sh = {s_r.sh[6:0], 1'b0};
              s_nxt.oe = !s_r.sh[6];
            end
          end
        end
        DBVC_MACK: begin
          if (scl_rise) begin
            s_nxt.mack = !s_r.sda_s;
          end else if (scl_fall) begin
            s_nxt.cnt = 4'h0;
            if (s_r.mack) begin
              s_nxt.st = DBVC_TX;
              s_nxt.sh = rd_byte;
              s_nxt.oe = !rd_byte[7];
            end else begin
              s_nxt.st = DBVC_IDLE;
            end
          end
        end
        default: begin
          s_nxt.st = DBVC_IDLE;
          s_nxt.oe = 1'b0;
        end
      endcase
    end

    // output code stepping
    if (s_r.ctrl[DBVC_CTRL_USTEP] && ramp) begin
      if (s_r.tmr == STEP_LAST) begin
        s_nxt.tmr  = '0;
        s_nxt.act1 = dbvc_step(s_r.act1, tgt1);
        s_nxt.act2 = dbvc_step(s_r.act2, tgt2);
      end else begin
        s_nxt.tmr = s_r.tmr + DBVC_TMR_W'(1);
      end
    end else begin
      s_nxt.tmr  = '0;
      s_nxt.act1 = tgt1;
      s_nxt.act2 = tgt2;
    end
    s_nxt.stp = (s_nxt.tmr != '0);
  end

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      s_r       <= '0;
      s_r.scl_m <= 1'b1;
      s_r.scl_s <= 1'b1;
      s_r.scl_p <= 1'b1;
      s_r.sda_m <= 1'b1;
      s_r.sda_s <= 1'b1;
      s_r.sda_p <= 1'b1;
      s_r.st    <= DBVC_IDLE;
      s_r.ctrl  <= DBVC_CTRL_RST;
      s_r.ch1   <= {3'b000, CH1_DEFAULT_CODE};
      s_r.ch2   <= {3'b000, CH2_DEFAULT_CODE};
      s_r.act1  <= CH1_DEFAULT_CODE;
      s_r.act2  <= CH2_DEFAULT_CODE;
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign sda_out                       = 1'b0;
  assign sda_oe_out                    = s_r.oe;
  assign ch1_code_out                  = s_r.act1;
  assign ch2_code_out                  = s_r.act2;
  assign ch1_force_pwm_out             = s_r.ch1[DBVC_CH_PWM];
  assign ch2_force_pwm_out             = s_r.ch2[DBVC_CH_PWM];
  assign ss_enable_out                 = s_r.ctrl[DBVC_CTRL_SS_EN];
  assign ss_fmod_1k_out                = s_r.ctrl[DBVC_CTRL_FMOD];
  assign output_good_indicator_dis_out = s_r.ch2[DBVC_CH2_GOOD_DIS];
  assign bus_busy_out                  = s_r.busy;
  assign stepping_out                  = s_r.stp;

endmodule
`default_nettype wire

// ==== dbvc_assertions.sv ====
// dbvc_assertions: bus timing and stepping checks on dbvc_top ports.
// assumes one core clock domain, bound onto dbvc_top.
`timescale 1ns/100ps
`default_nettype none
module dbvc_assertions (
  input wire logic       ref_clk_in,
  input wire logic       rstn_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic [4:0] ch1_code_out,
  input wire logic [4:0] ch2_code_out,
  input wire logic       bus_busy_out,
  input wire logic       stepping_out
);
  // ---------------------------------------------
  // stepping cycles since last ch1 move
  // ---------------------------------------------
  logic [9:0] run_r;
  logic [4:0] prev_r;
  always_ff @(posedge ref_clk_in) begin
    prev_r <= ch1_code_out;
    run_r  <= (!stepping_out || prev_r != ch1_code_out) ? 10'h000 : run_r + 10'h001;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_start; scl_in && $past(scl_in) && $fell(sda_in); endsequence
  sequence s_stop; scl_in && $past(scl_in) && $rose(sda_in); endsequence
  AST_BUSY_START: assert property (s_start |-> ##[2:5] bus_busy_out)
    else $error("busy not raised after start");
  AST_BUSY_STOP: assert property (s_stop |-> ##[2:5] !bus_busy_out)
    else $error("busy not cleared after stop");
  AST_SDA_STABLE: assert property (
    scl_in && $past(scl_in) |-> $stable(sda_oe_out))
    else $error("data moved while clock high");
  AST_OE_AFTER_FALL: assert property ($changed(sda_oe_out) |->
    $past(scl_in, 4) && !$past(scl_in, 3))
    else $error("data drive not four clocks after fall");
  AST_IDLE_FREE: assert property (
    !bus_busy_out && !$past(bus_busy_out) |-> !sda_oe_out)
    else $error("data driven on idle bus");
  AST_OPEN_DRAIN: assert property (sda_oe_out |-> !sda_out && !sda_in)
    else $error("data not pulled low while driven");
  AST_CH1_STEP: assert property ($changed(ch1_code_out) && $past(stepping_out) |->
    (ch1_code_out - $past(ch1_code_out)) inside {5'h01, 5'h1f})
    else $error("ch1 moved more than one code");
  AST_CH2_STEP: assert property ($changed(ch2_code_out) && $past(stepping_out) |->
    (ch2_code_out - $past(ch2_code_out)) inside {5'h01, 5'h1f})
    else $error("ch2 moved more than one code");
  AST_STEP_GAP: assert property ($changed(ch1_code_out) && $past(stepping_out) |->
    run_r inside {[310:330]})
    else $error("ch1 step spacing wrong");
endmodule
bind dbvc_top dbvc_assertions chk (.ref_clk_in, .rstn_in, .scl_in, .sda_in, .sda_out,
  .sda_oe_out, .ch1_code_out, .ch2_code_out, .bus_busy_out, .stepping_out);
`default_nettype wire

// ==== dbvc_master.sv ====
// dbvc_master: two-wire bus master model, 800 ns bit period.
// assumes an open-drain data wire with pull-up resolved outside.
`timescale 1ns/100ps
`default_nettype none
module dbvc_master (
  input  wire logic ref_clk_in,
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // one bus phase, lines change just after an edge
  task automatic ph(input logic c, input logic d, input int n);
    @(posedge ref_clk_in);
    scl_out <= c;
    sda_out <= d;
    repeat (n - 1) @(posedge ref_clk_in);
  endtask
  // start and repeated start
  task automatic start;
    ph(1'b0, sda_out, 1);
    ph(1'b0, 1'b1, 3);
    ph(1'b1, 1'b1, 4);
    ph(1'b1, 1'b0, 4);
  endtask
  task automatic stop;
    ph(1'b0, sda_out, 1);
    ph(1'b0, 1'b0, 3);
    ph(1'b1, 1'b0, 4);
    ph(1'b1, 1'b1, 4);
  endtask
  // msb first, ninth clock from master
  task automatic xfer(input logic [7:0] d, input logic ak,
                      output logic [7:0] q, output logic na);
    for (int i = 8; i >= 0; i--) begin
      ph(1'b0, sda_out, 1);
      ph(1'b0, i > 0 ? d[i-1] : ak, 3);
      ph(1'b1, sda_out, 4);
      if (i > 0) q[i-1] = sda_in;
      else na = sda_in;
    end
  endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// tb_top: self-checking bench for dbvc_top with a bus master model.
// assumes dbvc_pkg compiled first; 10 MHz core clock.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import dbvc_pkg::*;
  localparam logic [4:0] D1 = 5'h0b;
  localparam logic [4:0] D2 = 5'h0e;
  localparam logic [7:0] CV [4] = '{8'h19, 8'hff, 8'hff, 8'h01};
  logic       ref_clk_in = 1'b0;
  logic       rstn_in    = 1'b0;
  logic       scl, sda_m, sda_oe, sda_o, sda, busy, stp, pw1, pw2, sse, fm, gd, na;
  logic [4:0] c1, c2;
  logic [9:0] old;
  logic [7:0] rm [3];
  logic [7:0] r, v;
  int         errors, n_tests, n;
  always #50 ref_clk_in = ~ref_clk_in;
  assign sda = sda_m & ~(sda_oe & ~sda_o);
  dbvc_master m (.ref_clk_in(ref_clk_in), .sda_in(sda), .scl_out(scl), .sda_out(sda_m));
  dbvc_top #(.CH1_DEFAULT_CODE(D1), .CH2_DEFAULT_CODE(D2)) uut (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(1'b1), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .ch1_code_out(c1), .ch2_code_out(c2),
    .ch1_force_pwm_out(pw1), .ch2_force_pwm_out(pw2), .ss_enable_out(sse),
    .ss_fmod_1k_out(fm), .output_good_indicator_dis_out(gd), .bus_busy_out(busy),
    .stepping_out(stp));
  function automatic logic [7:0] msk(input int i);
    return i == 1 ? DBVC_CH1_MASK : i == 2 ? DBVC_CH2_MASK : 8'hff;
  endfunction
  function automatic logic [9:0] ramp_exp(input int s);
    return {s < 3 ? 5'(6 + s) : 5'h08, s < 3 ? 5'h03 : 5'(5 - s)};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic byt(input logic [7:0] d, input logic bad);
    m.xfer(d, 1'b1, r, na);
    chk(16'(na), 16'(bad));
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] i, input logic [7:0] d);
    m.start;
    byt(a, a[7:1] != DBVC_DEV_ADDR);
    byt(i, a[7:1] != DBVC_DEV_ADDR);
    byt(d, a[7:1] != DBVC_DEV_ADDR);
    m.stop;
  endtask
  task automatic rd(input logic [7:0] i);
    m.start;
    byt(8'h6c, 1'b0);
    byt(i, 1'b0);
    m.start;
    byt(8'h6d, 1'b0);
    m.xfer(8'hff, 1'b1, r, na);
    m.stop;
  endtask
  task automatic outs;
    @(negedge ref_clk_in);
    chk(16'(c1), 16'(rm[1][4:0]));
    chk(16'(c2), 16'(rm[2][4:0]));
    chk(16'({pw1, pw2, gd}), 16'({rm[1][5], rm[2][5], rm[2][6]}));
    chk(16'({fm, sse, busy}), 16'({rm[0][2:1], 1'b0}));
  endtask
  initial begin
    void'($urandom(32'h5005));
    rm = '{DBVC_CTRL_RST, {3'h0, D1}, {3'h0, D2}};
    repeat (10) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    outs;
    for (int k = 0; k < 18; k++) begin
      n = k < 4 ? 1 + k % 2 : $urandom_range(3, 0);
      v = k < 4 ? CV[k] : 8'($urandom);
      if (n == 0) v[0] = 1'b0;
      if (k == 5) wr(8'h6e, 8'h00, 8'h01);
      else wr(8'h6c, 8'(n), v);
      if (n < 3 && k != 5) rm[n] = v & msk(n);
      rd(8'(n));
      chk(16'(r), 16'(n < 3 ? rm[n] : 8'h00));
      outs;
    end
    wr(8'h6c, 8'h01, 8'h05);
    wr(8'h6c, 8'h02, 8'h03);
    wr(8'h6c, 8'h00, 8'h05);
    for (int s = 0; s < 5; s++) begin
      if (s == 0 || s == 3) begin
        wr(8'h6c, 8'(s / 3 + 1), s == 0 ? 8'h08 : 8'h01);
        @(negedge ref_clk_in);
        old = {c1, c2};
        chk(16'(old), 16'({s == 0 ? 5'h05 : 5'h08, 5'h03}));
      end
      n = 0;
      do begin
        @(negedge ref_clk_in);
        n++;
      end while ({c1, c2} === old && n < 400);
      if (n >= 400) begin
        errors++;
        end_of_test;
      end
      chk(16'({c1, c2}), 16'(ramp_exp(s)));
      if (s != 0 && s != 3) chk(16'(n), 16'(DBVC_STEP_CYC));
      old = {c1, c2};
    end
    repeat (2) @(negedge ref_clk_in);
    chk(16'(stp), 16'h0000);
    end_of_test;
  end
endmodule
`default_nettype wire
